// [common/pwr_ctrl_consts.vh]
// Register offsets, field positions, reset values and timing counts
`ifndef PWR_CTRL_CONSTS_VH
`define PWR_CTRL_CONSTS_VH
`define NUM_GPIO        21
`define OFS_MODE_CTRL   8'h00
`define OFS_DOMAIN_CTRL 8'h04
`define OFS_CMP_CFG     8'h08
`define OFS_STATUS      8'h0C
`define OFS_WAKE_PEND   8'h10
`define OFS_GPIO_WEN    8'h14
`define OFS_GPIO_EDGE   8'h18
`define OFS_TMR0_CNT    8'h1C
`define OFS_TMR0_CMP    8'h20
`define OFS_TMR1_CNT    8'h24
`define OFS_TMR1_CMP    8'h28
`define MODE_DOZE_BIT   0
`define MODE_SLEEP_BIT  1
`define MODE_DEEP_BIT   2
`define DOM_ANA_BIT     0
`define DOM_RAM_BIT     1
`define DOM_TMR0_BIT    2
`define DOM_TMR1_BIT    3
`define DOM_OSC_BIT     4
`define DOMAIN_RESET    32'h0000001F
`define CMP_CFG_RESET   32'h00000000
`define PEND_TMR0_BIT   0
`define PEND_TMR1_BIT   1
`define PEND_CMP0_BIT   2
`define PEND_CMP1_BIT   3
`define PEND_GPIO_BIT   4
`define NEG_SRC_VREF    2'h0
`define NEG_SRC_DAC     2'h1
`define NEG_SRC_PIN     2'h2
`define OSC_SETTLE_US   1000
`define OSC_SETTLE_CYC  ((`OSC_SETTLE_US * 10) / 1)
`define CPU_PWR_US      10
`define CPU_PWR_CYC     ((`CPU_PWR_US * 10) / 1)
`endif

// [dv/sleep_wakeup_power_control_assertions.sv]
// Port-level checks for the power controller
`timescale 1ns/1ps
`default_nettype none
module sleep_wakeup_power_control_assertions
(
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        cpuIrq,
    input wire logic        radioReq,
    input wire logic        oscStable,
    input wire logic        osc16mEn,
    input wire logic        osc32kEn,
    input wire logic        digitalPwrEn,
    input wire logic        analogPwrEn,
    input wire logic        cpuHalt,
    input wire logic        cpuResetN,
    input wire logic        radioPwrEn,
    input wire logic        dacHighZ,
    input wire logic        chipResetReq,
    input wire logic [20:0] pinOut,
    input wire logic [20:0] pinOe,
    input wire logic [20:0] pinPull,
    input wire logic [1:0]  firstCmpNegSel,
    input wire logic [1:0]  secondCmpNegSel
);
    // ==========
    // Checks
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);
    wire asleep = !osc16mEn;
    chk_dom_off: assert property (asleep |-> !digitalPwrEn && !analogPwrEn)
        else $error("domain powered while asleep");
    chk_dac_hiz: assert property (asleep |-> dacHighZ)
        else $error("dac driven while asleep");
    chk_neg_pin: assert property (asleep && osc32kEn |->
        firstCmpNegSel == 2'h2 && secondCmpNegSel == 2'h2)
        else $error("negative input not on pin");
    chk_pin_hold: assert property (asleep && $past(asleep) |->
        $stable(pinOut) && $stable(pinOe) && $stable(pinPull))
        else $error("pad state moved while asleep");
    chk_osc_first: assert property ($rose(digitalPwrEn) |->
        oscStable && $past(oscStable, 3))
        else $error("power before stable clock");
    chk_pwr_hold: assert property ($rose(cpuResetN) |->
        digitalPwrEn && $past(cpuResetN, 90) == 1'b0)
        else $error("cpu reset released early");
    chk_deep_rst: assert property ($rose(chipResetReq) |-> !osc32kEn && !digitalPwrEn)
        else $error("chip reset outside deep sleep");
    chk_rst_stays: assert property (chipResetReq |=> chipResetReq)
        else $error("chip reset request dropped");
    chk_doze_end: assert property (cpuHalt && cpuIrq |-> ##[1:3] !cpuHalt)
        else $error("doze not ended by interrupt");
    chk_radio_on: assert property (radioReq && cpuResetN && digitalPwrEn |->
        ##[0:1] radioPwrEn)
        else $error("radio not powered on request");
    cov_wake: cover property ($rose(cpuResetN));
    cov_deep: cover property ($rose(chipResetReq));
    cov_doze: cover property (cpuHalt && cpuIrq);
endmodule
`default_nettype wire

// [dv/sleep_wakeup_power_control_bench.sv]
// Self-checking bench for the power controller
`timescale 1ns/1ps
`default_nettype none
`include "pwr_ctrl_consts.vh"
module sleep_wakeup_power_control_bench;
    logic        sys_clk, rst, avsRead, avsWrite, avsWaitRequest, tick32k, cpuIrq, radioReq;
    logic        oscStable, firstCmpOut, secondCmpOut, cpuHalt, cpuResetN, digitalPwrEn;
    logic        analogPwrEn, ramPwrEn, radioPwrEn, osc16mEn, osc32kEn, dacHighZ, chipResetReq;
    logic        cmpIrq;
    logic [7:0]  avsAddress;
    logic [31:0] avsWriteData, avsReadData, q, v;
    logic [20:0] pinIn, pinOutReq, pinOeReq, pinPullReq, pinOut, pinOe, pinPull, hold;
    logic [1:0]  hystSel, firstCmpNegSel, secondCmpNegSel, cmpEnable, cmpLowPower;
    int          err_count, checks, k, i;
    // ==========
    // Design and far side
    sleep_wakeup_power_control #(.OSC_SETTLE_CYCLES(12)) sleep_wakeup_power_control_inst (
        .sys_clk(sys_clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(4'hF),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .tick32k(tick32k),
        .cpuIrq(cpuIrq), .radioReq(radioReq), .oscStable(oscStable), .firstCmpOut(firstCmpOut),
        .secondCmpOut(secondCmpOut), .pinIn(pinIn), .pinOutReq(pinOutReq), .pinOeReq(pinOeReq),
        .pinPullReq(pinPullReq), .pinOut(pinOut), .pinOe(pinOe), .pinPull(pinPull),
        .cpuHalt(cpuHalt), .cpuResetN(cpuResetN), .digitalPwrEn(digitalPwrEn),
        .analogPwrEn(analogPwrEn), .ramPwrEn(ramPwrEn), .radioPwrEn(radioPwrEn),
        .osc16mEn(osc16mEn), .osc32kEn(osc32kEn), .dacHighZ(dacHighZ), .chipResetReq(chipResetReq),
        .hystSel(hystSel), .firstCmpNegSel(firstCmpNegSel), .secondCmpNegSel(secondCmpNegSel),
        .cmpEnable(cmpEnable), .cmpLowPower(cmpLowPower), .cmpIrq(cmpIrq));
    wake_partner wake_partner_inst (.sys_clk(sys_clk), .rst(rst), .osc16mEn(osc16mEn),
        .osc32kEn(osc32kEn), .tick32k(tick32k), .oscStable(oscStable));
    always #50 sys_clk = !sys_clk;
    // ==========
    // Tasks
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks++;
        if (g !== e)
        begin
            err_count++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWrite <= w;
        avsRead <= !w;
        avsWriteData <= d;
        @(posedge sys_clk);
        while (avsWaitRequest !== 1'b0) @(posedge sys_clk);
        q = avsReadData;
        avsRead <= 1'b0;
        avsWrite <= 1'b0;
        @(posedge sys_clk);
    endtask
    task automatic go_sleep(input logic ram);
        bus(1'b1, `OFS_MODE_CTRL, 32'h2);
        chk("asleep", {ram, 7'h1A},
            {ramPwrEn, digitalPwrEn, analogPwrEn, dacHighZ, firstCmpNegSel, secondCmpNegSel});
    endtask
    task automatic wait_wake;
        int n;
        n = 0;
        while (!(cpuResetN === 1'b1 && digitalPwrEn === 1'b1 && osc16mEn === 1'b1) && n < 3000)
        begin
            @(posedge sys_clk);
            n++;
        end
        chk("wake", 1, n < 3000);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    initial
    begin
        repeat (30000) @(posedge sys_clk);
        err_count++;
        close_out;
    end
    // ==========
    // Scenarios
    initial
    begin
        {sys_clk, avsRead, avsWrite, cpuIrq, radioReq, firstCmpOut, secondCmpOut} = 7'h00;
        {avsAddress, avsWriteData, pinIn} = 61'h0;
        rst = 1'b1;
        err_count = 0;
        checks = 0;
        void'($urandom(32'hEF9F8F00));
        {pinOutReq, pinOeReq, pinPullReq} = {21'($urandom), 21'($urandom), 21'($urandom)};
        repeat (16) @(posedge sys_clk);
        rst <= 1'b0;
        @(posedge sys_clk);
        bus(1'b0, `OFS_DOMAIN_CTRL, 32'h0);
        chk("domain", `DOMAIN_RESET, q);
        bus(1'b0, `OFS_TMR0_CMP, 32'h0);
        chk("tmrCmp", 32'hFFFFFFFF, q);
        bus(1'b1, 8'hFC, $urandom);
        bus(1'b0, 8'hFC, 32'h0);
        chk("unmapped", 32'h0, q);
        for (i = 0; i < 4; i++)
        begin
            v = ($urandom & 32'h3C0) | (($urandom % 3) << 4) | (($urandom % 3) << 2) | i;
            bus(1'b1, `OFS_CMP_CFG, v);
            bus(1'b0, `OFS_CMP_CFG, 32'h0);
            chk("cmpCfg", v, q);
            chk("cmpPorts", v,
                {cmpLowPower, cmpEnable, secondCmpNegSel, firstCmpNegSel, hystSel});
            firstCmpOut <= $urandom;
            secondCmpOut <= $urandom;
            @(posedge sys_clk);
            bus(1'b0, `OFS_STATUS, 32'h0);
            chk("levels", {v[7] & secondCmpOut, v[6] & firstCmpOut, 1'b0},
                q & 32'h6);
        end
        {firstCmpOut, secondCmpOut} <= 2'h0;
        bus(1'b1, `OFS_MODE_CTRL, 32'h1);
        bus(1'b0, `OFS_MODE_CTRL, 32'h0);
        chk("doze", 32'h80000001, {cpuHalt, q[30:0]});
        cpuIrq <= 1'b1;
        repeat (3) @(posedge sys_clk);
        chk("dozeEnd", 0, cpuHalt);
        cpuIrq <= 1'b0;
        radioReq <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk("radio", 1, radioPwrEn);
        radioReq <= 1'b0;
        bus(1'b1, `OFS_WAKE_PEND, 32'h1F);
        bus(1'b1, `OFS_TMR0_CMP, 32'd30);
        bus(1'b1, `OFS_TMR0_CNT, 32'h0);
        go_sleep(1'b1);
        wait_wake;
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk("wakeFlag", 1, q[0]);
        bus(1'b0, `OFS_WAKE_PEND, 32'h0);
        chk("tmrPend", 1, q[0]);
        bus(1'b0, `OFS_TMR0_CNT, 32'h0);
        chk("tmrRuns", 1, q > 32'd30);
        bus(1'b1, `OFS_STATUS, 32'h1);
        bus(1'b1, `OFS_WAKE_PEND, 32'h1F);
        bus(1'b0, `OFS_WAKE_PEND, 32'h0);
        chk("pendClr", 0, q & 32'h1F);
        k = $urandom % 21;
        bus(1'b1, `OFS_DOMAIN_CTRL, 32'h1);
        bus(1'b1, `OFS_GPIO_WEN, 32'h1 << k);
        bus(1'b1, `OFS_GPIO_EDGE, 32'h1 << k);
        go_sleep(1'b0);
        chk("osc32k", 0, osc32kEn);
        hold = pinOut;
        {pinOutReq, pinOeReq, pinPullReq} <= {21'($urandom), 21'($urandom), 21'($urandom)};
        repeat (4) @(posedge sys_clk);
        chk("padHold", hold, pinOut);
        pinIn <= pinIn | (21'h1 << k);
        wait_wake;
        bus(1'b0, `OFS_WAKE_PEND, 32'h0);
        chk("gpioPend", 32'h10, q & 32'h10);
        bus(1'b1, `OFS_WAKE_PEND, 32'h1F);
        bus(1'b1, `OFS_DOMAIN_CTRL, 32'h1F);
        bus(1'b1, `OFS_CMP_CFG, 32'h14C0);
        go_sleep(1'b1);
        firstCmpOut <= 1'b1;
        wait_wake;
        chk("cmpIrq", 1, cmpIrq);
        bus(1'b1, `OFS_STATUS, 32'h1);
        bus(1'b1, `OFS_MODE_CTRL, 32'h2);
        wait_wake;
        bus(1'b0, `OFS_STATUS, 32'h0);
        chk("reWake", 1, q[0]);
        bus(1'b1, `OFS_WAKE_PEND, 32'h1F);
        chk("cmpIrqClr", 0, cmpIrq);
        bus(1'b1, `OFS_GPIO_EDGE, 32'h0);
        bus(1'b1, `OFS_MODE_CTRL, 32'h4);
        chk("deep", 0, {osc32kEn, digitalPwrEn, chipResetReq});
        pinIn <= pinIn & ~(21'h1 << k);
        for (i = 0; i < 50 && chipResetReq !== 1'b1; i++) @(posedge sys_clk);
        chk("chipReset", 1, chipResetReq);
        close_out;
    end
endmodule
bind sleep_wakeup_power_control
    sleep_wakeup_power_control_assertions sleep_wakeup_power_control_assertions_inst (
    .sys_clk(sys_clk), .rst(rst), .cpuIrq(cpuIrq), .radioReq(radioReq), .oscStable(oscStable),
    .osc16mEn(osc16mEn), .osc32kEn(osc32kEn), .digitalPwrEn(digitalPwrEn),
    .analogPwrEn(analogPwrEn),
    .cpuHalt(cpuHalt), .cpuResetN(cpuResetN), .radioPwrEn(radioPwrEn), .dacHighZ(dacHighZ),
    .chipResetReq(chipResetReq), .pinOut(pinOut), .pinOe(pinOe), .pinPull(pinPull),
    .firstCmpNegSel(firstCmpNegSel), .secondCmpNegSel(secondCmpNegSel));
`default_nettype wire

// [dv/wake_partner.sv]
// Far-side model: slow tick source and fast oscillator start-up
`timescale 1ns/1ps
`default_nettype none
module wake_partner
#(
    parameter logic [7:0] TICK_DIV = 8'h08,
    parameter logic [7:0] SETTLE   = 8'h06
)
(
    input  wire logic sys_clk,
    input  wire logic rst,
    input  wire logic osc16mEn,
    input  wire logic osc32kEn,
    output var  logic tick32k,
    output var  logic oscStable
);
    logic [7:0] divCnt;
    logic [7:0] oscCnt;
    // ==========
    // Oscillators
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            divCnt <= 8'h00;
            oscCnt <= 8'h00;
            tick32k <= 1'b0;
            oscStable <= 1'b0;
        end
        else
        begin
            // Slow tick only while the sleep oscillator runs
            divCnt <= (osc32kEn && divCnt != TICK_DIV - 8'h01) ? divCnt + 8'h01 : 8'h00;
            tick32k <= osc32kEn && divCnt == TICK_DIV - 8'h01;
            // Stable some cycles after start, lost when stopped
            oscCnt <= !osc16mEn ? 8'h00 : (oscCnt == SETTLE ? oscCnt : oscCnt + 8'h01);
            oscStable <= osc16mEn && oscCnt == SETTLE;
        end
    end
endmodule
`default_nettype wire

// [hw/gpio_wake_detect.v]
// Per-pin edge detection for GPIO wakeup
`timescale 1ns/1ps
`default_nettype none
module gpio_wake_detect
(
    input  wire        sys_clk,
    input  wire        rst,
    input  wire [20:0] pinIn,
    input  wire [20:0] wakeEn,
    input  wire [20:0] riseSel,
    output wire [20:0] edgeHit
);
    reg  [20:0] prev_ff;
    genvar i;
    generate
        for (i = 0; i < 21; i = i + 1)
        begin : g_pin
            // Raw pin level, independent of alternate function
            assign edgeHit[i] = wakeEn[i] &&
                (riseSel[i] ? (pinIn[i] && !prev_ff[i]) : (!pinIn[i] && prev_ff[i]));
        end
    endgenerate
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            prev_ff <= 21'h000000;
        else
            prev_ff <= pinIn;
    end
endmodule
`default_nettype wire

// [hw/sleep_wakeup_power_control.v]
// Power mode, wakeup sequencing and comparator configuration controller
//
// Added by the designer: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "pwr_ctrl_consts.vh"
// Notes on behaviour
// - Shared hysteresis select, four levels
// - Per-comparator negative input source select
// - Comparator levels readable and interrupt capable
// - Comparator enable and low-power mode
// - Comparator wake enable and edge select
// - Sleep forces negative input to pins
// - Active, sleep and deep sleep modes
// - Always-on domain; timers, oscillator switchable
// - Digital domain off during sleep
// - Analogue domain off in sleep, switchable
// - RAM retention selectable before sleep
// - Radio power follows baseband requests
// - Doze stops CPU until interrupt
// - GPIO state held during sleep
// - DAC outputs high impedance in sleep
// - GPIO, timer, comparator events wake device
// - Pending wakeups cause immediate re-wake
// - Wake: oscillator, settle, power, release reset
// - Two 32-bit free-running wakeup counters
// - Per-pin wake edge enable and select
// - Wake detect works under alternate functions
// - Deep sleep exits only via GPIO reset
module sleep_wakeup_power_control
#(
    parameter OSC_SETTLE_CYCLES = `OSC_SETTLE_CYC
)
(
    input  wire        sys_clk,
    input  wire        rst,
    input  wire [7:0]  avsAddress,
    input  wire        avsRead,
    input  wire        avsWrite,
    input  wire [31:0] avsWriteData,
    input  wire [3:0]  avsByteEnable,
    output reg  [31:0] avsReadData,
    output wire        avsWaitRequest,
    input  wire        tick32k,
    input  wire        cpuIrq,
    input  wire        radioReq,
    input  wire        oscStable,
    input  wire        firstCmpOut,
    input  wire        secondCmpOut,
    input  wire [20:0] pinIn,
    input  wire [20:0] pinOutReq,
    input  wire [20:0] pinOeReq,
    input  wire [20:0] pinPullReq,
    output reg  [20:0] pinOut,
    output reg  [20:0] pinOe,
    output reg  [20:0] pinPull,
    output wire        cpuHalt,
    output wire        cpuResetN,
    output wire        digitalPwrEn,
    output wire        analogPwrEn,
    output wire        ramPwrEn,
    output wire        radioPwrEn,
    output wire        osc16mEn,
    output wire        osc32kEn,
    output wire        dacHighZ,
    output wire        chipResetReq,
    output wire [1:0]  hystSel,
    output wire [1:0]  firstCmpNegSel,
    output wire [1:0]  secondCmpNegSel,
    output wire [1:0]  cmpEnable,
    output wire [1:0]  cmpLowPower,
    output wire        cmpIrq
);
    // ==========================================================
    // State encoding
    localparam ST_ACTIVE = 3'h0;
    localparam ST_DOZE   = 3'h1;
    localparam ST_SLEEP  = 3'h2;
    localparam ST_DEEP   = 3'h3;
    localparam ST_OSC    = 3'h4;
    localparam ST_PWR    = 3'h5;
    localparam ST_RESET  = 3'h6;

    reg  [2:0]  state_ff;
    reg  [2:0]  nxt_state;
    reg  [31:0] domain_ff;
    reg  [31:0] cmpCfg_ff;
    reg  [4:0]  pend_ff;
    reg  [4:0]  nxt_pend;
    reg         wakeRst_ff;
    reg         nxt_wakeRst;
    reg  [20:0] gpioWen_ff;
    reg  [20:0] gpioEdge_ff;
    reg  [31:0] tmr0Cmp_ff;
    reg  [31:0] tmr1Cmp_ff;
    reg  [31:0] wait_ff;
    reg  [31:0] nxt_wait;
    reg  [1:0]  cmpPrev_ff;
    reg         modeWr;
    reg         chipRst_ff;
    reg         rdDone_ff;
    wire [31:0] tmr0Count;
    wire [31:0] tmr1Count;
    wire        tmr0Fire;
    wire        tmr1Fire;
    wire [20:0] gpioHit;
    wire [1:0]  cmpLevel;
    wire [1:0]  cmpHit;
    wire [4:0]  events;
    wire        wrHit;
    wire        inSleep;

    // ==========================================================
    // Bus slave, one wait state on reads so registered data stands at accept
    assign avsWaitRequest = avsRead && !rdDone_ff;
    assign wrHit = avsWrite;

    // ==========================================================
    // Wakeup timers
    wake_timer u_tmr0
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick32k (tick32k && domain_ff[`DOM_OSC_BIT]),
        .runEn   (domain_ff[`DOM_TMR0_BIT]),
        .loadEn  (wrHit && avsAddress == `OFS_TMR0_CNT),
        .loadVal (avsWriteData),
        .cmpVal  (tmr0Cmp_ff),
        .count_ff(tmr0Count),
        .fire_ff (tmr0Fire)
    );
    wake_timer u_tmr1
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .tick32k (tick32k && domain_ff[`DOM_OSC_BIT]),
        .runEn   (domain_ff[`DOM_TMR1_BIT]),
        .loadEn  (wrHit && avsAddress == `OFS_TMR1_CNT),
        .loadVal (avsWriteData),
        .cmpVal  (tmr1Cmp_ff),
        .count_ff(tmr1Count),
        .fire_ff (tmr1Fire)
    );

    // ==========================================================
    // GPIO wakeup detection
    gpio_wake_detect u_gpio
    (
        .sys_clk (sys_clk),
        .rst     (rst),
        .pinIn   (pinIn),
        .wakeEn  (gpioWen_ff),
        .riseSel (gpioEdge_ff),
        .edgeHit (gpioHit)
    );

    // ==========================================================
    // Comparator configuration
    // cfg[1:0] hyst, [3:2] neg0, [5:4] neg1, [7:6] en, [9:8] lowpwr,
    // [11:10] wake en, [13:12] wake rising edge
    assign inSleep = (state_ff == ST_SLEEP);
    assign hystSel = cmpCfg_ff[1:0];
    assign firstCmpNegSel  = inSleep ? `NEG_SRC_PIN : cmpCfg_ff[3:2];
    assign secondCmpNegSel = inSleep ? `NEG_SRC_PIN : cmpCfg_ff[5:4];
    assign cmpEnable   = cmpCfg_ff[7:6];
    assign cmpLowPower = cmpCfg_ff[9:8];
    assign cmpLevel = {secondCmpOut, firstCmpOut} & cmpEnable;
    genvar c;
    generate
        for (c = 0; c < 2; c = c + 1)
        begin : g_cmp
            assign cmpHit[c] = cmpCfg_ff[10 + c] &&
                (cmpCfg_ff[12 + c] ? (cmpLevel[c] && !cmpPrev_ff[c])
                                   : (!cmpLevel[c] && cmpPrev_ff[c]));
        end
    endgenerate
    assign cmpIrq = |(pend_ff[3:2]);

    // ==========================================================
    // Wake event collection
    assign events = {|gpioHit, cmpHit, tmr1Fire, tmr0Fire};
    always @*
    begin
        nxt_pend = pend_ff;
        if (wrHit && avsAddress == `OFS_WAKE_PEND)
            nxt_pend = pend_ff & ~avsWriteData[4:0];
        nxt_pend = nxt_pend | events; // Set wins over clear
    end

    // ==========================================================
    // Power mode sequencer
    always @*
    begin
        modeWr = wrHit && avsAddress == `OFS_MODE_CTRL && avsByteEnable[0];
        nxt_state = state_ff;
        nxt_wait  = wait_ff;
        nxt_wakeRst = wakeRst_ff;
        if (wrHit && avsAddress == `OFS_STATUS && avsWriteData[0])
            nxt_wakeRst = 1'b0;
        case (state_ff)
            ST_ACTIVE:
            begin
                if (modeWr && avsWriteData[`MODE_DEEP_BIT])
                    nxt_state = ST_DEEP;
                else if (modeWr && avsWriteData[`MODE_SLEEP_BIT])
                    nxt_state = ST_SLEEP;
                else if (modeWr && avsWriteData[`MODE_DOZE_BIT])
                    nxt_state = ST_DOZE;
            end
            ST_DOZE:
                if (cpuIrq)
                    nxt_state = ST_ACTIVE;
            ST_SLEEP:
                if (|pend_ff)
                begin
                    nxt_state = ST_OSC; // Pending wake exits at once
                    nxt_wait  = 32'h00000000;
                end
            ST_DEEP:
                if (|gpioHit)
                    nxt_state = ST_RESET;
            ST_OSC:
                if (oscStable && wait_ff >= OSC_SETTLE_CYCLES)
                begin
                    nxt_state = ST_PWR;
                    nxt_wait  = 32'h00000000;
                end
                else
                    nxt_wait = wait_ff + 32'h00000001;
            ST_PWR:
                if (wait_ff >= `CPU_PWR_CYC)
                begin
                    nxt_state = ST_ACTIVE;
                    nxt_wakeRst = 1'b1;
                end
                else
                    nxt_wait = wait_ff + 32'h00000001;
            ST_RESET:
                nxt_state = ST_RESET;
            default:
                nxt_state = ST_ACTIVE;
        endcase
    end

    // Domain and clock controls per mode
    assign cpuHalt      = (state_ff != ST_ACTIVE);
    assign digitalPwrEn = (state_ff == ST_ACTIVE) || (state_ff == ST_DOZE) ||
                          (state_ff == ST_PWR);
    assign cpuResetN    = (state_ff == ST_ACTIVE) || (state_ff == ST_DOZE);
    assign analogPwrEn  = digitalPwrEn && (state_ff != ST_PWR) &&
                          domain_ff[`DOM_ANA_BIT];
    assign ramPwrEn     = digitalPwrEn || (state_ff == ST_OSC) ||
                          (inSleep && domain_ff[`DOM_RAM_BIT]);
    assign radioPwrEn   = digitalPwrEn && radioReq;
    assign osc16mEn     = (state_ff != ST_SLEEP) && (state_ff != ST_DEEP);
    assign osc32kEn     = (state_ff != ST_DEEP) && (state_ff != ST_RESET) &&
                          domain_ff[`DOM_OSC_BIT];
    assign dacHighZ     = inSleep || (state_ff == ST_DEEP);
    assign chipResetReq = chipRst_ff;

    // ==========================================================
    // Registers
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            state_ff    <= ST_ACTIVE;
            domain_ff   <= `DOMAIN_RESET;
            cmpCfg_ff   <= `CMP_CFG_RESET;
            pend_ff     <= 5'h00;
            wakeRst_ff  <= 1'b0;
            gpioWen_ff  <= 21'h000000;
            gpioEdge_ff <= 21'h000000;
            tmr0Cmp_ff  <= 32'hFFFFFFFF;
            tmr1Cmp_ff  <= 32'hFFFFFFFF;
            wait_ff     <= 32'h00000000;
            cmpPrev_ff  <= 2'h0;
            chipRst_ff  <= 1'b0;
            pinOut      <= 21'h000000;
            pinOe       <= 21'h000000;
            pinPull     <= 21'h000000;
        end
        else
        begin
            state_ff   <= nxt_state;
            pend_ff    <= nxt_pend;
            wakeRst_ff <= nxt_wakeRst;
            wait_ff    <= nxt_wait;
            cmpPrev_ff <= cmpLevel;
            chipRst_ff <= (nxt_state == ST_RESET);
            if (!dacHighZ)
            begin
                pinOut  <= pinOutReq; // Frozen in sleep
                pinOe   <= pinOeReq;
                pinPull <= pinPullReq;
            end
            if (wrHit && avsAddress == `OFS_DOMAIN_CTRL)
                domain_ff <= avsWriteData & `DOMAIN_RESET;
            if (wrHit && avsAddress == `OFS_CMP_CFG)
                cmpCfg_ff <= {18'h00000, avsWriteData[13:0]};
            if (wrHit && avsAddress == `OFS_GPIO_WEN)
                gpioWen_ff <= avsWriteData[20:0];
            if (wrHit && avsAddress == `OFS_GPIO_EDGE)
                gpioEdge_ff <= avsWriteData[20:0];
            if (wrHit && avsAddress == `OFS_TMR0_CMP)
                tmr0Cmp_ff <= avsWriteData;
            if (wrHit && avsAddress == `OFS_TMR1_CMP)
                tmr1Cmp_ff <= avsWriteData;
        end
    end

    // ==========================================================
    // Read data
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            avsReadData <= 32'h00000000;
        else if (avsRead && !rdDone_ff)
        begin
            case (avsAddress)
                `OFS_MODE_CTRL:   avsReadData <= {29'h00000000, state_ff};
                `OFS_DOMAIN_CTRL: avsReadData <= domain_ff;
                `OFS_CMP_CFG:     avsReadData <= cmpCfg_ff;
                `OFS_STATUS:      avsReadData <= {29'h00000000, cmpLevel, wakeRst_ff};
                `OFS_WAKE_PEND:   avsReadData <= {27'h0000000, pend_ff};
                `OFS_GPIO_WEN:    avsReadData <= {11'h000, gpioWen_ff};
                `OFS_GPIO_EDGE:   avsReadData <= {11'h000, gpioEdge_ff};
                `OFS_TMR0_CNT:    avsReadData <= tmr0Count;
                `OFS_TMR0_CMP:    avsReadData <= tmr0Cmp_ff;
                `OFS_TMR1_CNT:    avsReadData <= tmr1Count;
                `OFS_TMR1_CMP:    avsReadData <= tmr1Cmp_ff;
                default:          avsReadData <= 32'h00000000;
            endcase
        end
    end

    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
            rdDone_ff <= 1'b0;
        else
            rdDone_ff <= avsRead && !rdDone_ff;
    end
endmodule
`default_nettype wire

// [hw/wake_timer.v]
// One 32-bit free-running wakeup counter with compare event
`timescale 1ns/1ps
`default_nettype none
module wake_timer
(
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        tick32k,
    input  wire        runEn,
    input  wire        loadEn,
    input  wire [31:0] loadVal,
    input  wire [31:0] cmpVal,
    output reg  [31:0] count_ff,
    output reg         fire_ff
);
    reg [31:0] nxt_count;
    always @*
    begin
        nxt_count = count_ff;
        if (loadEn)
            nxt_count = loadVal;
        else if (runEn && tick32k)
            nxt_count = count_ff + 32'h00000001; // Keeps counting after firing
    end
    always @(posedge sys_clk or posedge rst)
    begin
        if (rst)
        begin
            count_ff <= 32'h00000000;
            fire_ff  <= 1'b0;
        end
        else
        begin
            count_ff <= nxt_count;
            fire_ff  <= runEn && tick32k && !loadEn && (nxt_count == cmpVal);
        end
    end
endmodule
`default_nettype wire
